/* design/vofr_l11_if.sv */
// vofr_l11_if.sv: carries a Linear-11 code and its fixed-point value.
// assumes a converter on the conv side and a reader on the user side.
`timescale 1ns/1ps
`include "vofr_regs.svh"
interface vofr_l11_if;
	logic [15:0] code;
	logic signed [`VOFR_FIX_WIDTH-1:0] value;
	modport conv (input code, output value);
	modport user (output code, input value);
endinterface

/* design/vofr_linear11.sv */
// vofr_linear11.sv: Linear-11 to signed fixed point with 16 fraction bits.
// assumes a purely combinational use.
`timescale 1ns/1ps
`include "vofr_regs.svh"
module vofr_linear11
(
	vofr_l11_if.conv port
);
	logic signed [4:0] expo;
	logic signed [10:0] mant;
	logic [4:0] shift;
	logic signed [`VOFR_FIX_WIDTH-1:0] wide;

	always_comb
	begin
		expo = port.code[15:11];
		mant = port.code[10:0];
		// exponent -16..15 maps to shift 0..31
		shift = 5'(expo + 5'sd16);
		wide = `VOFR_FIX_WIDTH'(mant);
		// value = mantissa * 2^exponent
		port.value = wide <<< shift;
	end
endmodule

/* design/vofr_pkg.sv */
// vofr_pkg.sv: types of the input overvoltage fault response block.
// assumes vofr_regs.svh is on the include path.
package vofr_pkg;
	typedef enum logic [4:0]
	{
		ST_OFF = 5'h01,
		ST_RUN = 5'h02,
		ST_LATCH = 5'h04,
		ST_HYST = 5'h08,
		ST_RETRY = 5'h10
	} vofr_mode_t;

	typedef struct packed
	{
		logic [15:0] faultLimit;
		logic [15:0] warnLimit;
		logic [7:0] action;
		logic [15:0] vin;
		logic vinSeen;
		vofr_mode_t mode;
		logic faultBit;
		logic warnBit;
		logic [31:0] timer;
		logic outEn;
		logic respValid;
		logic respError;
		logic [15:0] respData;
	} vofr_state_t;
endpackage

/* design/vofr_regs.svh */
// vofr_regs.svh: offsets, field positions, reset values and timing counts
// of the input overvoltage fault response block; included by its bare name.
// Overview of operation
// - fault threshold is two-byte Linear-11, mantissa times two to the exponent, volts
// - threshold resets to the 14 V code and accepts settings 0 to 19 V
// - threshold and response are single global values, read/write, write protectable
// - response setting resets to output disable with no retry
// - fault pulls alert low and sets a fault bit kept until clear faults
// - response code 10 disables output then retries per retry field; 00, 01 unused
// - response code 11 keeps output off until input falls below warning limit
// - retry field 000 means no restart until fault cleared; 001 to 110 unused
// - retry field 111 retries until commanded off, bias lost or another fault
// - each continuous retry starts only after input falls below warning limit
// - attempt starts spaced by (delay field plus one) times 35 ms
// - warning limit is a separate global Linear-11 value reset to 13.5 V
`ifndef VOFR_REGS_SVH
`define VOFR_REGS_SVH

`define VOFR_CMD_CLEAR_FAULTS 8'h03
`define VOFR_CMD_FAULT_LIMIT 8'h55
`define VOFR_CMD_FAULT_ACTION 8'h56
`define VOFR_CMD_WARN_LIMIT 8'h57
`define VOFR_CMD_STATUS_INPUT 8'h7c

`define VOFR_FAULT_LIMIT_RESET 16'hd380
`define VOFR_FAULT_ACTION_RESET 8'h80
`define VOFR_WARN_LIMIT_RESET 16'hd360

`define VOFR_ACT_RESP_HI 7
`define VOFR_ACT_RESP_LO 6
`define VOFR_ACT_RETRY_HI 5
`define VOFR_ACT_RETRY_LO 3
`define VOFR_ACT_DELAY_HI 2
`define VOFR_ACT_DELAY_LO 0
`define VOFR_RESP_HOLD_OFF 2'h3
`define VOFR_RETRY_CONTINUOUS 3'h7

`define VOFR_STATUS_FAULT_BIT 7
`define VOFR_STATUS_WARN_BIT 6

`define VOFR_FIX_FRAC 16
`define VOFR_FIX_WIDTH 42
`define VOFR_RANGE_MAX_FIX 42'h00000130000

`define VOFR_CLK_PERIOD_NS 10
`define VOFR_RETRY_UNIT_MS 35
`define VOFR_RETRY_UNIT_CYC ((`VOFR_RETRY_UNIT_MS * 1000000) / `VOFR_CLK_PERIOD_NS)

`endif

/* design/vofr_top.sv */
// vofr_top.sv: input overvoltage fault limit, response and retry logic.
// assumes a command port decoded from the host bus and synchronous inputs.
`timescale 1ns/1ps
`include "vofr_regs.svh"
module vofr_top
#(
	parameter int unsigned RETRY_UNIT_CYCLES = `VOFR_RETRY_UNIT_CYC
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clockEnable,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdWriteData,
	input wire logic writeProtect,
	output logic respValid,
	output logic respError,
	output logic [15:0] respData,
	input wire logic vinValid,
	input wire logic [15:0] vinSample,
	input wire logic outputCommanded,
	input wire logic biasGood,
	input wire logic otherFault,
	output logic outputEnable,
	output logic alertOutputLow,
	output vofr_pkg::vofr_mode_t responseMode
);
	import vofr_pkg::*;

	localparam int NCONV = 4;
	localparam int CV_VIN = 0;
	localparam int CV_FAULT = 1;
	localparam int CV_WARN = 2;
	localparam int CV_WDATA = 3;

	vofr_state_t state;
	vofr_state_t next_state;

	vofr_l11_if conv [NCONV] ();
	logic [15:0] convCode [NCONV];
	logic signed [`VOFR_FIX_WIDTH-1:0] convValue [NCONV];

	logic overFault;
	logic aboveWarn;
	logic belowWarn;
	logic stopReq;
	logic clearCmd;
	logic writeCmd;
	logic readCmd;
	logic dataInRange;
	logic [1:0] respCode;
	logic [2:0] retryCode;
	logic [31:0] delayCycles;

	assign convCode[CV_VIN] = state.vin;
	assign convCode[CV_FAULT] = state.faultLimit;
	assign convCode[CV_WARN] = state.warnLimit;
	assign convCode[CV_WDATA] = cmdWriteData;

	// one converter per Linear-11 quantity
	genvar gi;
	generate
		for (gi = 0; gi < NCONV; gi++)
		begin : gen_conv
			assign conv[gi].code = convCode[gi];
			assign convValue[gi] = conv[gi].value;
			vofr_linear11 u_conv
			(
				.port(conv[gi])
			);
		end
	endgenerate

	always_comb
	begin
		// fault when measured input exceeds the threshold
		overFault = state.vinSeen && (convValue[CV_VIN] > convValue[CV_FAULT]);
		aboveWarn = state.vinSeen && (convValue[CV_VIN] > convValue[CV_WARN]);
		// recovery level is the separate warning limit
		belowWarn = state.vinSeen && (convValue[CV_VIN] < convValue[CV_WARN]);
		// stop conditions for all restart attempts
		stopReq = !outputCommanded || !biasGood || otherFault;
		clearCmd = cmdValid && cmdWrite && (cmdCode == `VOFR_CMD_CLEAR_FAULTS);
		writeCmd = cmdValid && cmdWrite;
		readCmd = cmdValid && !cmdWrite;
		// settings accepted from 0 to 19 V
		dataInRange = (convValue[CV_WDATA] >= 0) &&
			(convValue[CV_WDATA] <= $signed(`VOFR_RANGE_MAX_FIX));
		respCode = state.action[`VOFR_ACT_RESP_HI:`VOFR_ACT_RESP_LO];
		retryCode = state.action[`VOFR_ACT_RETRY_HI:`VOFR_ACT_RETRY_LO];
		// spacing of attempt starts, (field + 1) units
		delayCycles = (32'(state.action[`VOFR_ACT_DELAY_HI:`VOFR_ACT_DELAY_LO]) + 32'h1) *
			RETRY_UNIT_CYCLES;
	end

	always_comb
	begin
		next_state = state;
		next_state.respValid = 1'b0;
		next_state.respError = 1'b0;

		// sample capture
		if (vinValid)
		begin
			next_state.vin = vinSample;
			next_state.vinSeen = 1'b1;
		end

		// command port: global, protectable settings
		if (writeCmd)
		begin
			next_state.respValid = 1'b1;
			case (cmdCode)
				`VOFR_CMD_FAULT_LIMIT:
				begin
					if (writeProtect || !dataInRange)
					begin
						next_state.respError = 1'b1;
					end
					else
					begin
						next_state.faultLimit = cmdWriteData;
					end
				end
				`VOFR_CMD_FAULT_ACTION:
				begin
					if (writeProtect)
					begin
						next_state.respError = 1'b1;
					end
					else
					begin
						next_state.action = cmdWriteData[7:0];
					end
				end
				`VOFR_CMD_WARN_LIMIT:
				begin
					if (writeProtect || !dataInRange)
					begin
						next_state.respError = 1'b1;
					end
					else
					begin
						next_state.warnLimit = cmdWriteData;
					end
				end
				`VOFR_CMD_CLEAR_FAULTS:
				begin
					// fault bits cleared only here
					next_state.faultBit = 1'b0;
					next_state.warnBit = 1'b0;
				end
				default:
				begin
					next_state.respError = 1'b1;
				end
			endcase
		end

		if (readCmd)
		begin
			next_state.respValid = 1'b1;
			next_state.respData = 16'h0000;
			case (cmdCode)
				`VOFR_CMD_FAULT_LIMIT:
				begin
					next_state.respData = state.faultLimit;
				end
				`VOFR_CMD_FAULT_ACTION:
				begin
					next_state.respData = {8'h00, state.action};
				end
				`VOFR_CMD_WARN_LIMIT:
				begin
					next_state.respData = state.warnLimit;
				end
				`VOFR_CMD_STATUS_INPUT:
				begin
					next_state.respData[`VOFR_STATUS_FAULT_BIT] = state.faultBit;
					next_state.respData[`VOFR_STATUS_WARN_BIT] = state.warnBit;
				end
				default:
				begin
					next_state.respError = 1'b1;
				end
			endcase
		end

		// sticky flags; a new event wins over clear faults
		if (overFault)
		begin
			next_state.faultBit = 1'b1;
		end
		if (aboveWarn)
		begin
			next_state.warnBit = 1'b1;
		end

		// attempt spacing timer runs in every state
		if (state.timer != 32'h0)
		begin
			next_state.timer = state.timer - 32'h1;
		end

		case (state.mode)
			ST_OFF:
			begin
				next_state.outEn = 1'b0;
				if (!stopReq)
				begin
					next_state.mode = ST_RUN;
					// no enable pulse into a standing fault
					next_state.outEn = !overFault;
				end
			end
			ST_RUN:
			begin
				if (overFault)
				begin
					// output disabled on every response
					next_state.outEn = 1'b0;
					if (respCode == `VOFR_RESP_HOLD_OFF)
					begin
						next_state.mode = ST_HYST;
					end
					else if (retryCode == `VOFR_RETRY_CONTINUOUS)
					begin
						// unused codes 00, 01 behave as 10
						next_state.mode = ST_RETRY;
						if (state.timer == 32'h0)
						begin
							next_state.timer = delayCycles;
						end
					end
					else
					begin
						next_state.mode = ST_LATCH;
					end
				end
			end
			ST_LATCH:
			begin
				// no restart until the fault is cleared
				next_state.outEn = 1'b0;
				if (clearCmd)
				begin
					next_state.mode = ST_OFF;
				end
			end
			ST_HYST:
			begin
				next_state.outEn = 1'b0;
				// resume once input is below the warning limit
				if (belowWarn)
				begin
					next_state.mode = ST_RUN;
					next_state.outEn = 1'b1;
				end
			end
			ST_RETRY:
			begin
				next_state.outEn = 1'b0;
				// start only below warning and after the delay
				if (belowWarn && (state.timer == 32'h0))
				begin
					next_state.mode = ST_RUN;
					next_state.outEn = 1'b1;
					next_state.timer = delayCycles;
				end
			end
			default:
			begin
				next_state.mode = ST_OFF;
				next_state.outEn = 1'b0;
			end
		endcase

		// commanded off, bias loss or another fault ends retries
		if (stopReq && (state.mode != ST_LATCH))
		begin
			next_state.mode = ST_OFF;
			next_state.outEn = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			state.faultLimit <= `VOFR_FAULT_LIMIT_RESET;
			state.warnLimit <= `VOFR_WARN_LIMIT_RESET;
			state.action <= `VOFR_FAULT_ACTION_RESET;
			state.vin <= 16'h0000;
			state.vinSeen <= 1'b0;
			state.mode <= ST_OFF;
			state.faultBit <= 1'b0;
			state.warnBit <= 1'b0;
			state.timer <= 32'h0;
			state.outEn <= 1'b0;
			state.respValid <= 1'b0;
			state.respError <= 1'b0;
			state.respData <= 16'h0000;
		end
		else if (clockEnable)
		begin
			state <= next_state;
		end
	end

	assign respValid = state.respValid;
	assign respError = state.respError;
	assign respData = state.respData;
	assign outputEnable = state.outEn;
	// alert pulled low while the fault bit stands
	assign alertOutputLow = !state.faultBit;
	assign responseMode = state.mode;
endmodule

/* test/vofr_top_monitor.sv */
// vofr_top_monitor.sv: port assertions of the overvoltage fault block.
// assumes a bind onto vofr_top.
`timescale 1ns/1ps
module vofr_top_monitor
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clockEnable,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic writeProtect,
	input wire logic respValid,
	input wire logic respError,
	input wire logic biasGood,
	input wire logic outputEnable,
	input wire logic alertOutputLow,
	input wire vofr_pkg::vofr_mode_t responseMode
);
	import vofr_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence sTaken;
		cmdValid && clockEnable;
	endsequence
	sequence sBlocked;
		sTaken ##0 (cmdWrite && writeProtect && cmdCode != 8'h03);
	endsequence
	wire clearCmd = cmdValid && clockEnable && cmdWrite && cmdCode == 8'h03;
	AST_ANSWER: assert property (sTaken |=> respValid)
		else $error("command not answered");
	AST_QUIET: assert property (clockEnable && !cmdValid |=> !respValid)
		else $error("answer without command");
	AST_PROTECT: assert property (sBlocked |=> respValid && respError)
		else $error("protected write accepted");
	AST_LATCHED: assert property (responseMode == ST_LATCH |-> !outputEnable && !alertOutputLow)
		else $error("latched state with output on");
	AST_STICKY: assert property (!alertOutputLow && !clearCmd |=> !alertOutputLow)
		else $error("alert released without clear");
	AST_STOP: assert property (clockEnable && !biasGood && responseMode != ST_LATCH |=> !outputEnable)
		else $error("output on without bias");
	AST_ONEHOT: assert property ($onehot(responseMode))
		else $error("mode not one-hot");
	AST_ALERTOFF: assert property ($fell(alertOutputLow) |-> !outputEnable)
		else $error("alert raised with output on");
	AST_ERRPAIR: assert property (respError |-> respValid)
		else $error("error without answer");
endmodule

/* test/vofr_top_tb.sv */
// vofr_top_tb.sv: self-checking bench of the overvoltage fault block.
// assumes design/ on the include path.
`timescale 1ns/1ps
module vofr_top_tb;
	import vofr_pkg::*;
	localparam int U = 20;
	typedef struct {logic w; logic [7:0] c; logic [15:0] d; logic e; logic [15:0] q;} vofr_row_t;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic clockEnable = 1'b1;
	logic cmdValid = 1'b0;
	logic cmdWrite = 1'b0;
	logic [7:0] cmdCode = 8'h00;
	logic [15:0] cmdWriteData = 16'h0000;
	logic writeProtect = 1'b0;
	logic outputCommanded = 1'b1;
	logic biasGood = 1'b1;
	logic otherFault = 1'b0;
	logic [15:0] level = 16'hd300;
	logic respValid, respError, vinValid, outputEnable, alertOutputLow;
	logic [15:0] respData, vinSample, q;
	logic e;
	vofr_mode_t responseMode;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;
	int n;
	vofr_row_t rows[13] = '{
		'{0, 8'h55, 16'h0, 0, 16'hd380}, '{0, 8'h56, 16'h0, 0, 16'h0080},
		'{0, 8'h57, 16'h0, 0, 16'hd360}, '{0, 8'h03, 16'h0, 1, 16'h0},
		'{0, 8'h99, 16'h0, 1, 16'h0}, '{1, 8'h55, 16'hd3c0, 0, 16'h0},
		'{0, 8'h55, 16'h0, 0, 16'hd3c0}, '{1, 8'h55, 16'hda80, 1, 16'h0},
		'{0, 8'h55, 16'h0, 0, 16'hd3c0}, '{1, 8'h56, 16'h00bf, 0, 16'h0},
		'{0, 8'h56, 16'h0, 0, 16'h00bf}, '{1, 8'h56, 16'h0080, 0, 16'h0},
		'{1, 8'h55, 16'hd380, 0, 16'h0}};
	vofr_top #(.RETRY_UNIT_CYCLES(U)) u_dut (.clock(clock), .reset_n(reset_n),
		.clockEnable(clockEnable), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
		.cmdCode(cmdCode), .cmdWriteData(cmdWriteData), .writeProtect(writeProtect),
		.respValid(respValid), .respError(respError), .respData(respData),
		.vinValid(vinValid), .vinSample(vinSample), .outputCommanded(outputCommanded),
		.biasGood(biasGood), .otherFault(otherFault), .outputEnable(outputEnable),
		.alertOutputLow(alertOutputLow), .responseMode(responseMode));
	vofr_vin_source u_src (.clock(clock), .reset_n(reset_n), .level(level),
		.vinValid(vinValid), .vinSample(vinSample));
	initial
	begin
		forever #5 clock = ~clock;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		check_count++;
		if (s !== x)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
		@(negedge clock);
		cmdValid = 1'b1;
		cmdWrite = w;
		cmdCode = c;
		cmdWriteData = d;
		@(negedge clock);
		cmdValid = 1'b0;
		chk({15'h0, respValid}, 16'h1);
		e = respError;
		q = respData;
	endtask
	task automatic wt(input int k);
		repeat (k) @(negedge clock);
	endtask
	task automatic stat(input logic oe, input logic al, input vofr_mode_t m);
		chk({9'h0, outputEnable, alertOutputLow, responseMode}, {9'h0, oe, al, m});
	endtask
	task automatic waitOn(input logic v);
		n = 0;
		while (outputEnable !== v && n < 400)
		begin
			@(negedge clock);
			n++;
		end
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			print_verdict();
		end
	end
	initial
	begin
		wt(8);
		reset_n = 1'b1;
		foreach (rows[i])
		begin
			cmd(rows[i].w, rows[i].c, rows[i].d);
			chk({15'h0, e}, {15'h0, rows[i].e});
			if (!rows[i].w && !rows[i].e)
				chk(q, rows[i].q);
		end
		stat(1'b1, 1'b1, ST_RUN);
		writeProtect = 1'b1;
		cmd(1'b1, 8'h56, 16'h00c0);
		chk({15'h0, e}, 16'h1);
		writeProtect = 1'b0;
		cmd(1'b0, 8'h56, 16'h0);
		chk(q, 16'h0080);
		level = 16'hd3c0;
		wt(10);
		stat(1'b0, 1'b0, ST_LATCH);
		cmd(1'b0, 8'h7c, 16'h0);
		chk(q & 16'h0080, 16'h0080);
		level = 16'hd340;
		wt(20);
		stat(1'b0, 1'b0, ST_LATCH);
		cmd(1'b1, 8'h03, 16'h0);
		wt(4);
		stat(1'b1, 1'b1, ST_RUN);
		cmd(1'b1, 8'h56, 16'h00c0);
		level = 16'hd3c0;
		wt(10);
		stat(1'b0, 1'b0, ST_HYST);
		level = 16'hd370;
		wt(10);
		chk({15'h0, outputEnable}, 16'h0);
		level = 16'hd340;
		wt(10);
		chk({15'h0, outputEnable}, 16'h1);
		cmd(1'b1, 8'h03, 16'h0);
		cmd(1'b1, 8'h56, 16'h00bf);
		level = 16'hd3c0;
		waitOn(1'b0);
		level = 16'hd340;
		waitOn(1'b1);
		chk({15'h0, n >= 8 * U - 4 && n <= 8 * U + 8}, 16'h1);
		level = 16'hd3c0;
		waitOn(1'b0);
		wt(300);
		chk({15'h0, outputEnable}, 16'h0);
		level = 16'hd340;
		wt(10);
		chk({15'h0, outputEnable}, 16'h1);
		otherFault = 1'b1;
		wt(3);
		stat(1'b0, 1'b0, ST_OFF);
		otherFault = 1'b0;
		biasGood = 1'b0;
		wt(3);
		chk({15'h0, outputEnable}, 16'h0);
		biasGood = 1'b1;
		wt(3);
		stat(1'b1, 1'b0, ST_RUN);
		outputCommanded = 1'b0;
		wt(3);
		stat(1'b0, 1'b0, ST_OFF);
		outputCommanded = 1'b1;
		wt(3);
		clockEnable = 1'b0;
		level = 16'hd3c0;
		wt(10);
		stat(1'b1, 1'b0, ST_RUN);
		clockEnable = 1'b1;
		wt(10);
		stat(1'b0, 1'b0, ST_RETRY);
		level = 16'hd340;
		reset_n = 1'b0;
		wt(2);
		reset_n = 1'b1;
		cmd(1'b0, 8'h56, 16'h0);
		chk(q, 16'h0080);
		stat(1'b1, 1'b1, ST_RUN);
		print_verdict();
	end
endmodule
bind vofr_top vofr_top_monitor u_mon (.clock(clock), .reset_n(reset_n),
	.clockEnable(clockEnable), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
	.cmdCode(cmdCode), .writeProtect(writeProtect), .respValid(respValid),
	.respError(respError), .biasGood(biasGood), .outputEnable(outputEnable),
	.alertOutputLow(alertOutputLow), .responseMode(responseMode));

/* test/vofr_vin_source.sv */
// vofr_vin_source.sv: input voltage sensor model, one sample every 4 cycles.
// assumes the bench sets the level to report.
`timescale 1ns/1ps
module vofr_vin_source
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [15:0] level,
	output logic vinValid,
	output logic [15:0] vinSample
);
	logic [1:0] phase;
	always_ff @(posedge clock)
	begin
		phase <= reset_n ? phase + 2'h1 : 2'h0;
		vinValid <= reset_n && (phase == 2'h3);
		// between samples the bus shows a changing pattern
		vinSample <= (reset_n && phase == 2'h3) ? level : ~vinSample;
	end
endmodule
